// ===== common/power_clock_pkg.sv
// constants and types shared by the power mode and clock control block
// ---------------------------------------------------------------------
// Summary of operation
// R1 - normal mode clocks core and all peripherals; the code clocks only peripherals whose periph_enable_q bit is set
// R2 - idle halts core, peripherals clocked, interrupt wakes
// R3 - stop: clear select, set stop; reset exits
// R4 - shutdown: set select, set stop; pin/por exits
// R5 - software selects high freq clock before snooze
// R6 - snooze halts clocks, oscillators, regulator low bias
// R7 - snooze keeps timers 3/4; four wake events
// R8 - unused digital peripherals have clocks gated off
// R9 - reset clock is 24.5 MHz divided by 8
// R10 - system clock source selectable from eight options
// R11 - divider by 1 to 128 in eight settings
// R12 - request bits clear on wake, back to normal
// ---------------------------------------------------------------------
package power_clock_pkg;

  // ---------------------------------------------------------------------
  // register offsets, data width and field positions
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_POWER_CONTROL_FIRST = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_POWER_CONTROL_SECOND = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_REGULATOR_CONTROL = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_SELECT = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_PERIPH_CLOCK_ENABLE = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_MODE_STATUS = 3'h5;

  localparam int unsigned POS_IDLE = 0;
  localparam int unsigned POS_STOP = 1;
  localparam int unsigned POS_SNOOZE = 0;
  localparam int unsigned POS_SHUTDOWN_SELECT = 0;
  localparam int unsigned POS_SRC_LSB = 0;
  localparam int unsigned POS_DIV_LSB = 4;
  localparam int unsigned POS_MODE_LSB = 0;
  localparam int unsigned POS_HF_ON = 4;
  localparam int unsigned POS_FS_ON = 5;
  localparam int unsigned POS_LOW_BIAS = 6;

  // ---------------------------------------------------------------------
  // clock sources, divider and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned NUM_SRC = 8;
  localparam logic [2:0] SRC_HF_49 = 3'h0;
  localparam logic [2:0] SRC_FS_10 = 3'h1;
  localparam logic [2:0] SRC_LF_80K = 3'h2;
  localparam logic [2:0] SRC_EXT = 3'h3;
  localparam logic [2:0] SRC_HF_24P5 = 3'h4;
  localparam logic [2:0] SRC_HF_24P5_DIV1P5 = 3'h5;
  localparam logic [2:0] SRC_FS_2P5 = 3'h6;
  localparam logic [2:0] SRC_HF_49_DIV1P5 = 3'h7;

  localparam logic [2:0] RST_SRC = SRC_HF_24P5;
  localparam logic [2:0] RST_DIV = 3'h3;
  localparam logic [7:0] RST_PERIPH_ENABLE = 8'h00;
  localparam int unsigned DIV_CNT_W = 7;
  localparam logic [2:0] LF_TIMER_DIV_LAST = 3'h7;

  // ---------------------------------------------------------------------
  // power modes
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_IDLE = 3'b001,
    MODE_STOP = 3'b010,
    MODE_SNOOZE = 3'b011,
    MODE_SHUTDOWN = 3'b100
  } power_mode_t;

endpackage

// ===== design/power_mode_and_clock_control.sv
// power mode sequencing and system clock selection and division
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module power_mode_and_clock_control #(
  parameter int unsigned NUM_PERIPH = 8
) (
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [power_clock_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [power_clock_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [power_clock_pkg::DATA_W-1:0] reg_rdata,
  // raw oscillator outputs, asynchronous to clk
  input wire logic [power_clock_pkg::NUM_SRC-1:0] source_clock_in,
  // wake and exit sources
  input wire logic interrupt_pending,
  input wire logic timer4_event,
  input wire logic port_match_event,
  input wire logic comparator0_in,
  input wire logic configurable_logic_unit_irq_event,
  input wire logic soft_reset_event,
  // clock enables and power controls
  output logic system_clock_tick,
  output logic core_clock_en,
  output logic [NUM_PERIPH-1:0] periph_clock_en,
  output logic timer34_low_freq_tick,
  output logic high_freq_oscillator_en,
  output logic fast_startup_oscillator_en,
  output logic regulator_low_bias,
  output logic internal_power_off,
  output logic pin_state_hold,
  output logic core_halted
);
  import power_clock_pkg::*;

  if (NUM_PERIPH < 1 || NUM_PERIPH > DATA_W) begin : g_bad_periph
    $error("NUM_PERIPH must lie between 1 and the register width");
  end

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic is_high_freq_source(input logic [2:0] src);
    is_high_freq_source = (src == SRC_HF_49) || (src == SRC_HF_24P5) ||
                          (src == SRC_HF_24P5_DIV1P5) || (src == SRC_HF_49_DIV1P5);
  endfunction

  function automatic logic is_fast_startup_source(input logic [2:0] src);
    is_fast_startup_source = (src == SRC_FS_10) || (src == SRC_FS_2P5);
  endfunction

  // stop and shutdown both freeze the pins
  function automatic logic holds_pins(input power_mode_t m);
    holds_pins = (m == MODE_STOP) || (m == MODE_SHUTDOWN);
  endfunction

  function automatic logic clocks_peripherals(input power_mode_t m);
    clocks_peripherals = (m == MODE_NORMAL) || (m == MODE_IDLE);
  endfunction

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  power_mode_t mode_q;
  power_mode_t mode_d;
  logic idle_req_q;
  logic stop_req_q;
  logic snooze_req_q;
  logic shutdown_select_q;
  logic [2:0] src_sel_q;
  logic [2:0] div_sel_q;
  logic [NUM_PERIPH-1:0] periph_enable_q;
  logic [DIV_CNT_W-1:0] div_cnt_q;
  logic [2:0] lf_cnt_q;
  logic [NUM_SRC-1:0] src_s1_q;
  logic [NUM_SRC-1:0] src_s2_q;
  logic [NUM_SRC-1:0] src_s3_q;
  logic [NUM_SRC-1:0] src_level_q;
  logic [NUM_SRC-1:0] src_rise;
  logic cmp_s1_q;
  logic cmp_s2_q;
  logic cmp_s3_q;
  logic cmp_level_q;
  logic cmp_fall;
  logic wr_first;
  logic wr_second;
  logic wr_clock_select;
  logic snooze_wake;
  logic src_running;
  logic sel_rise;
  logic div_done;
  logic [DIV_CNT_W-1:0] div_last;

  assign wr_first = reg_wr && (reg_addr == OFF_POWER_CONTROL_FIRST);
  assign wr_second = reg_wr && (reg_addr == OFF_POWER_CONTROL_SECOND);
  assign wr_clock_select = reg_wr && (reg_addr == OFF_CLOCK_SELECT);

  // ---------------------------------------------------------------------
  // synchronisers for oscillator lines and comparator
  // ---------------------------------------------------------------------
  // a new level is accepted only once the second and third stages agree,
  // which keeps a single metastable sample from making a false edge
  // a source already high at release counts one rise, which only moves the first tick
  genvar gi;
  for (gi = 0; gi < NUM_SRC; gi++) begin : g_src_sync
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        src_s1_q[gi] <= 1'b0;
        src_s2_q[gi] <= 1'b0;
        src_s3_q[gi] <= 1'b0;
        src_level_q[gi] <= 1'b0;
      end else begin
        src_s1_q[gi] <= source_clock_in[gi];
        src_s2_q[gi] <= src_s1_q[gi];
        src_s3_q[gi] <= src_s2_q[gi];
        if (src_s2_q[gi] == src_s3_q[gi]) begin
          src_level_q[gi] <= src_s3_q[gi];
        end
      end
    end
    assign src_rise[gi] = (src_s2_q[gi] == src_s3_q[gi]) && src_s3_q[gi] && !src_level_q[gi];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      cmp_s3_q <= 1'b0;
      cmp_level_q <= 1'b0;
    end else begin
      cmp_s1_q <= comparator0_in;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      if (cmp_s2_q == cmp_s3_q) begin
        cmp_level_q <= cmp_s3_q;
      end
    end
  end

  assign cmp_fall = (cmp_s2_q == cmp_s3_q) && !cmp_s3_q && cmp_level_q;

  // ---------------------------------------------------------------------
  // mode sequencing
  // ---------------------------------------------------------------------
  assign snooze_wake = timer4_event || port_match_event || cmp_fall ||
                       configurable_logic_unit_irq_event; // [R7]

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_NORMAL: begin
        if (wr_first && reg_wdata[POS_STOP]) begin
          // the select bit is sampled here, so it must be written first
          mode_d = shutdown_select_q ? MODE_SHUTDOWN : MODE_STOP; // [R3] [R4]
        end else if (wr_first && reg_wdata[POS_IDLE]) begin
          mode_d = MODE_IDLE; // [R2]
        end else if (wr_second && reg_wdata[POS_SNOOZE]) begin
          mode_d = MODE_SNOOZE; // [R5] [R6]
        end
      end
      MODE_IDLE: begin
        if (interrupt_pending) begin
          mode_d = MODE_NORMAL; // [R2]
        end
      end
      MODE_STOP: begin
        if (soft_reset_event) begin
          mode_d = MODE_NORMAL; // [R3]
        end
      end
      MODE_SNOOZE: begin
        if (snooze_wake) begin
          mode_d = MODE_NORMAL; // [R6] [R7]
        end
      end
      // only the block reset, driven by pin or power-on reset, leaves here
      MODE_SHUTDOWN: mode_d = MODE_SHUTDOWN; // [R4]
      default: mode_d = MODE_NORMAL;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_NORMAL;
    end else begin
      mode_q <= mode_d;
    end
  end

  // request bits mirror the mode and drop on wake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_req_q <= 1'b0;
      stop_req_q <= 1'b0;
      snooze_req_q <= 1'b0;
    end else begin
      idle_req_q <= (mode_d == MODE_IDLE); // [R12]
      stop_req_q <= holds_pins(mode_d); // [R12]
      snooze_req_q <= (mode_d == MODE_SNOOZE); // [R12]
    end
  end

  // ---------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shutdown_select_q <= 1'b0;
    end else if (reg_wr && reg_addr == OFF_REGULATOR_CONTROL) begin
      shutdown_select_q <= reg_wdata[POS_SHUTDOWN_SELECT]; // [R3] [R4]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_sel_q <= RST_SRC; // [R9]
      div_sel_q <= RST_DIV; // [R9]
    end else if (wr_clock_select) begin
      src_sel_q <= reg_wdata[POS_SRC_LSB +: 3]; // [R10]
      div_sel_q <= reg_wdata[POS_DIV_LSB +: 3]; // [R11]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periph_enable_q <= RST_PERIPH_ENABLE[NUM_PERIPH-1:0];
    end else if (reg_wr && reg_addr == OFF_PERIPH_CLOCK_ENABLE) begin
      periph_enable_q <= reg_wdata[NUM_PERIPH-1:0]; // [R8]
    end
  end

  // ---------------------------------------------------------------------
  // source selection and divider
  // ---------------------------------------------------------------------
  // a stopped oscillator yields no edges, so the divider freezes with it
  assign src_running = (is_high_freq_source(src_sel_q) && high_freq_oscillator_en) ||
                       (is_fast_startup_source(src_sel_q) && fast_startup_oscillator_en) ||
                       (src_sel_q == SRC_LF_80K) || (src_sel_q == SRC_EXT);
  assign sel_rise = src_rise[src_sel_q] && src_running; // [R10]
  assign div_last = DIV_CNT_W'((8'h01 << div_sel_q) - 8'h01); // [R11]
  assign div_done = (div_cnt_q >= div_last);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= '0;
    end else if (wr_clock_select) begin
      div_cnt_q <= '0;
    end else if (sel_rise) begin
      div_cnt_q <= div_done ? '0 : div_cnt_q + 1'b1; // [R11]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      system_clock_tick <= 1'b0;
    end else begin
      system_clock_tick <= sel_rise && div_done; // [R9] [R11]
    end
  end

  // ---------------------------------------------------------------------
  // clock gating and power controls
  // ---------------------------------------------------------------------
  // gating is combinational on the tick so a halted core sees no stray edge
  assign core_clock_en = system_clock_tick && (mode_q == MODE_NORMAL); // [R1] [R2]

  for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph_gate
    assign periph_clock_en[gi] = system_clock_tick && periph_enable_q[gi] &&
      clocks_peripherals(mode_q); // [R1] [R2] [R6] [R8]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_freq_oscillator_en <= 1'b1;
      fast_startup_oscillator_en <= 1'b1;
      regulator_low_bias <= 1'b0;
      internal_power_off <= 1'b0;
      pin_state_hold <= 1'b0;
      core_halted <= 1'b0;
    end else begin
      high_freq_oscillator_en <= clocks_peripherals(mode_d); // [R3] [R6]
      fast_startup_oscillator_en <= (mode_d != MODE_SNOOZE) &&
                                    (mode_d != MODE_SHUTDOWN); // [R6]
      regulator_low_bias <= (mode_d == MODE_SNOOZE); // [R6]
      internal_power_off <= (mode_d == MODE_SHUTDOWN); // [R4]
      pin_state_hold <= holds_pins(mode_d); // [R3] [R4]
      core_halted <= (mode_d != MODE_NORMAL); // [R2] [R6]
    end
  end

  // low-frequency oscillator divided by eight keeps timers 3 and 4 alive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lf_cnt_q <= '0;
      timer34_low_freq_tick <= 1'b0;
    end else begin
      timer34_low_freq_tick <= 1'b0;
      if (src_rise[SRC_LF_80K] && mode_q != MODE_SHUTDOWN) begin
        lf_cnt_q <= lf_cnt_q + 1'b1;
        timer34_low_freq_tick <= (lf_cnt_q == LF_TIMER_DIV_LAST); // [R7]
      end
    end
  end

  // ---------------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      case (reg_addr)
        OFF_POWER_CONTROL_FIRST: begin
          reg_rdata[POS_IDLE] <= idle_req_q;
          reg_rdata[POS_STOP] <= stop_req_q;
        end
        OFF_POWER_CONTROL_SECOND: reg_rdata[POS_SNOOZE] <= snooze_req_q;
        OFF_REGULATOR_CONTROL: reg_rdata[POS_SHUTDOWN_SELECT] <= shutdown_select_q;
        OFF_CLOCK_SELECT: begin
          reg_rdata[POS_SRC_LSB +: 3] <= src_sel_q;
          reg_rdata[POS_DIV_LSB +: 3] <= div_sel_q;
        end
        OFF_PERIPH_CLOCK_ENABLE: reg_rdata[NUM_PERIPH-1:0] <= periph_enable_q;
        OFF_MODE_STATUS: begin
          reg_rdata[POS_MODE_LSB +: 3] <= mode_q;
          reg_rdata[POS_HF_ON] <= high_freq_oscillator_en;
          reg_rdata[POS_FS_ON] <= fast_startup_oscillator_en;
          reg_rdata[POS_LOW_BIAS] <= regulator_low_bias;
        end
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

`default_nettype wire

// ===== test/power_clock_checker.sv
// assertion checker for the power mode and clock control block
`timescale 1ns/1ps
`default_nettype none

module power_clock_checker #(
  parameter int unsigned NUM_PERIPH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic interrupt_pending,
  input wire logic timer4_event,
  input wire logic port_match_event,
  input wire logic configurable_logic_unit_irq_event,
  input wire logic soft_reset_event,
  input wire logic system_clock_tick,
  input wire logic core_clock_en,
  input wire logic [NUM_PERIPH-1:0] periph_clock_en,
  input wire logic timer34_low_freq_tick,
  input wire logic high_freq_oscillator_en,
  input wire logic fast_startup_oscillator_en,
  input wire logic regulator_low_bias,
  input wire logic internal_power_off,
  input wire logic pin_state_hold,
  input wire logic core_halted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // modes are told apart from the power outputs alone, the mode code is not a port
  logic in_idle;
  logic in_stop;
  logic snooze_wake;
  assign in_idle = core_halted && !pin_state_hold && !regulator_low_bias && !internal_power_off;
  assign in_stop = pin_state_hold && !internal_power_off && !regulator_low_bias;
  assign snooze_wake = timer4_event || port_match_event || configurable_logic_unit_irq_event;

  // ---------------------------------------------------------------------
  // mode behaviour
  // ---------------------------------------------------------------------
  a_normal_core_clock: assert property (!core_halted |-> core_clock_en == system_clock_tick)
    else $error("core clock enable differs from tick while running");
  a_halt_gates_core: assert property (core_halted |-> !core_clock_en)
    else $error("core clocked while halted");
  a_idle_osc_on: assert property (in_idle |-> high_freq_oscillator_en && fast_startup_oscillator_en)
    else $error("oscillator stopped in idle");
  a_idle_irq_wake: assert property (in_idle && interrupt_pending |=> !core_halted)
    else $error("interrupt did not end idle");
  a_stop_osc_off: assert property (in_stop |-> !high_freq_oscillator_en && core_halted)
    else $error("high freq oscillator running in stop");
  a_stop_holds: assert property (in_stop && !soft_reset_event |=> in_stop)
    else $error("stop left without a reset");
  a_shutdown_holds: assert property (
    internal_power_off |=> internal_power_off && pin_state_hold && !timer34_low_freq_tick)
    else $error("shutdown left without pin reset");
  a_snooze_gates: assert property (regulator_low_bias |-> !high_freq_oscillator_en &&
    !fast_startup_oscillator_en && periph_clock_en == '0 && core_halted)
    else $error("snooze left a clock or oscillator running");
  a_snooze_wake: assert property (
    regulator_low_bias && snooze_wake |=> !regulator_low_bias && !core_halted)
    else $error("wake event did not end snooze");
  a_release_normal: assert property ($fell(rst) |-> high_freq_oscillator_en &&
    fast_startup_oscillator_en && !core_halted && !pin_state_hold)
    else $error("not in normal mode after reset");
  c_idle_wake: cover property (in_idle && interrupt_pending);
  c_snooze_wake: cover property (regulator_low_bias && snooze_wake);
  c_shutdown: cover property (internal_power_off);
endmodule

`default_nettype wire

// ===== test/osc_wake_model.sv
// oscillator and wake source model on the far side of the block
`timescale 1ns/1ps
`default_nettype none

module osc_wake_model (
  input wire logic clk,
  input wire logic high_freq_oscillator_en,
  input wire logic fast_startup_oscillator_en,
  output logic [7:0] source_clock_in,
  output logic interrupt_pending,
  output logic timer4_event,
  output logic port_match_event,
  output logic comparator0_in,
  output logic configurable_logic_unit_irq_event,
  output logic soft_reset_event
);
  logic [7:0] raw;
  logic [7:0] run;
  logic [5:0] ev = 6'h00;
  // source i has a period of 2*(i+2) cycles, offset so no edge meets a clk edge
  for (genvar i = 0; i < 8; i++) begin : g_osc
    initial begin
      raw[i] = 1'b0;
      #3;
      forever #(10 * (i + 2)) raw[i] = ~raw[i];
    end
  end
  // a disabled oscillator stops dead, so a wrong enable shows as a missing tick
  assign run = {high_freq_oscillator_en, fast_startup_oscillator_en, {2{high_freq_oscillator_en}},
    2'b11, fast_startup_oscillator_en, high_freq_oscillator_en};
  assign source_clock_in = raw & run;
  assign interrupt_pending = ev[0];
  assign timer4_event = ev[1];
  assign port_match_event = ev[2];
  assign comparator0_in = ~ev[3];
  assign configurable_logic_unit_irq_event = ev[4];
  assign soft_reset_event = ev[5];

  // comparator input stays low long enough for the synchroniser to agree
  task automatic fire(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    repeat (k == 3 ? 8 : 1) @(posedge clk);
    ev[k] <= 1'b0;
    // let the block settle so the caller sees the result of this edge
    #1;
  endtask
endmodule

`default_nettype wire

// ===== test/tb.sv
// self-checking testbench for the power mode and clock control block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import power_clock_pkg::*;
  logic clk = 1'b0;
  logic rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_SRC-1:0] source_clock_in;
  logic interrupt_pending, timer4_event, port_match_event, comparator0_in;
  logic configurable_logic_unit_irq_event, soft_reset_event, system_clock_tick;
  logic core_clock_en, timer34_low_freq_tick, high_freq_oscillator_en;
  logic fast_startup_oscillator_en, regulator_low_bias, internal_power_off;
  logic pin_state_hold, core_halted;
  logic [7:0] periph_clock_en;
  int n_mismatch = 0;
  int tests_run = 0;

  always #5 clk = ~clk;

  power_mode_and_clock_control #(.NUM_PERIPH(8)) i_dut (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .source_clock_in,
    .interrupt_pending, .timer4_event, .port_match_event, .comparator0_in,
    .configurable_logic_unit_irq_event, .soft_reset_event, .system_clock_tick,
    .core_clock_en, .periph_clock_en, .timer34_low_freq_tick, .high_freq_oscillator_en,
    .fast_startup_oscillator_en, .regulator_low_bias, .internal_power_off,
    .pin_state_hold, .core_halted);

  osc_wake_model i_osc (
    .clk, .high_freq_oscillator_en, .fast_startup_oscillator_en, .source_clock_in,
    .interrupt_pending, .timer4_event, .port_match_event, .comparator0_in,
    .configurable_logic_unit_irq_event, .soft_reset_event);

  // ---------------------------------------------------------------------
  // bus and checking helpers
  // ---------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // first tick after a divider restart is skipped, then cycles to the next one
  task automatic gap(output int n);
    int c;
    c = 0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (system_clock_tick !== 1'b1 && c < 3000);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (system_clock_tick !== 1'b1 && n < 3000);
  endtask

  task automatic wait_on(input int which);
    int c;
    c = 0;
    while ((which ? timer34_low_freq_tick !== 1'b1 : core_halted !== 1'b0) && c < 100) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset();
    rd(OFF_MODE_STATUS, 8'h30);
    rd(OFF_CLOCK_SELECT, 8'h34);
    rd(OFF_PERIPH_CLOCK_ENABLE, 8'h00);
    chk(periph_clock_en, 8'h00);
    wr(3'h7, 8'hff);
    rd(3'h7, 8'h00);
    rd(3'h6, 8'h00);
  endtask

  task automatic t_clock();
    int n;
    for (int s = 0; s < 8; s++) begin
      wr(OFF_CLOCK_SELECT, 8'(s) | 8'h10);
      gap(n);
      chk(16'(n), 16'(4 * (s + 2)));
    end
    for (int d = 0; d < 8; d++) begin
      wr(OFF_CLOCK_SELECT, 8'(d << 4) | 8'h01);
      gap(n);
      chk(16'(n), 16'(6 << d));
    end
    wr(OFF_CLOCK_SELECT, 8'h01);
    wr(OFF_PERIPH_CLOCK_ENABLE, 8'ha5);
    gap(n);
    chk({core_clock_en, periph_clock_en}, 16'h01a5);
  endtask

  task automatic t_idle();
    int n;
    wr(OFF_POWER_CONTROL_FIRST, 8'h01);
    rd(OFF_MODE_STATUS, 8'h31);
    gap(n);
    chk({core_clock_en, periph_clock_en}, 16'h00a5);
    wr(OFF_POWER_CONTROL_FIRST, 8'h02);
    rd(OFF_MODE_STATUS, 8'h31);
    i_osc.fire(0);
    wait_on(0);
    chk(core_halted, 1'b0);
    rd(OFF_POWER_CONTROL_FIRST, 8'h00);
  endtask

  task automatic t_snooze();
    for (int k = 1; k < 5; k++) begin
      wr(OFF_CLOCK_SELECT, 8'h00);
      wr(OFF_POWER_CONTROL_SECOND, 8'h01);
      rd(OFF_MODE_STATUS, 8'h43);
      chk({core_halted, periph_clock_en}, 16'h0100);
      wait_on(1);
      chk(timer34_low_freq_tick, 1'b1);
      i_osc.fire(0);
      chk(core_halted, 1'b1);
      i_osc.fire(k);
      wait_on(0);
      chk(core_halted, 1'b0);
      rd(OFF_POWER_CONTROL_SECOND, 8'h00);
    end
  endtask

  task automatic t_stop();
    for (int d = 2; d < 4; d++) begin
      wr(OFF_REGULATOR_CONTROL, 8'h00);
      wr(OFF_POWER_CONTROL_FIRST, 8'(d));
      chk({pin_state_hold, high_freq_oscillator_en}, 16'h0002);
      rd(OFF_MODE_STATUS, 8'h22);
      i_osc.fire(0);
      chk(core_halted, 1'b1);
      i_osc.fire(5);
      wait_on(0);
      chk(core_halted, 1'b0);
      rd(OFF_POWER_CONTROL_FIRST, 8'h00);
    end
  endtask

  task automatic t_shutdown();
    wr(OFF_REGULATOR_CONTROL, 8'h01);
    wr(OFF_POWER_CONTROL_FIRST, 8'h02);
    chk({internal_power_off, pin_state_hold}, 16'h0003);
    rd(OFF_MODE_STATUS, 8'h04);
    i_osc.fire(5);
    chk(internal_power_off, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(internal_power_off, 1'b0);
    rd(OFF_CLOCK_SELECT, 8'h34);
  endtask

  task automatic results();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    rst <= 1'b1;
    reg_addr <= '0;
    reg_wdata <= '0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_clock();
    t_idle();
    t_snooze();
    t_stop();
    t_shutdown();
    results();
  end

  initial begin
    #500000;
    n_mismatch++;
    results();
  end
endmodule

bind power_mode_and_clock_control power_clock_checker #(.NUM_PERIPH(NUM_PERIPH)) i_chk (
  .clk, .rst, .interrupt_pending, .timer4_event, .port_match_event,
  .configurable_logic_unit_irq_event, .soft_reset_event, .system_clock_tick, .core_clock_en,
  .periph_clock_en, .timer34_low_freq_tick, .high_freq_oscillator_en,
  .fast_startup_oscillator_en, .regulator_low_bias, .internal_power_off, .pin_state_hold,
  .core_halted);

`default_nettype wire
